/* File: hdl/wutc_pkg.sv */
package wutc_pkg;
  // Register byte addresses
  localparam logic [31:0] WUTC_ADDR_VALUE_LOW   = 32'h4000_2500;
  localparam logic [31:0] WUTC_ADDR_VALUE_HIGH  = 32'h4000_2504;
  localparam logic [31:0] WUTC_ADDR_CONTROL     = 32'h4000_2508;
  localparam logic [31:0] WUTC_ADDR_ENABLE      = 32'h4000_250C;
  localparam logic [31:0] WUTC_ADDR_CMP_A_LOW   = 32'h4000_2510;
  localparam logic [31:0] WUTC_ADDR_CMP_A_HIGH  = 32'h4000_2514;
  localparam logic [31:0] WUTC_ADDR_CMP_B_LOW   = 32'h4000_2518;
  localparam logic [31:0] WUTC_ADDR_CMP_B_HIGH  = 32'h4000_251C;
  localparam logic [31:0] WUTC_ADDR_CMP_C_LOW   = 32'h4000_2520;
  localparam logic [31:0] WUTC_ADDR_CMP_C_HIGH  = 32'h4000_2524;
  localparam logic [31:0] WUTC_ADDR_IRQ_ENABLE  = 32'h4000_2528;
  localparam logic [31:0] WUTC_ADDR_IRQ_STATUS  = 32'h4000_252C;
  localparam logic [31:0] WUTC_ADDR_IRQ_CLEAR   = 32'h4000_2530;

  // Reset values
  localparam logic [15:0] WUTC_RST_ENABLE       = 16'h0000;
  localparam logic [15:0] WUTC_RST_CONTROL      = 16'h0000;
  localparam logic [15:0] WUTC_RST_CMP_A_LOW    = 16'h1FFF;
  localparam logic [15:0] WUTC_RST_CMP_B_LOW    = 16'h2FFF;
  localparam logic [15:0] WUTC_RST_CMP_C_LOW    = 16'h3FFF;
  localparam logic [15:0] WUTC_RST_CMP_HIGH     = 16'h0000;
  localparam logic [15:0] WUTC_RST_IRQ_ENABLE   = 16'h0000;

  // Field positions
  localparam int WUTC_ENABLE_BIT    = 0;
  localparam int WUTC_CTRL_FREE_BIT = 0;
  localparam int WUTC_CTRL_DEC_BIT  = 1;
  localparam int WUTC_MATCH_A_BIT   = 0;
  localparam int WUTC_MATCH_B_BIT   = 1;
  localparam int WUTC_MATCH_C_BIT   = 2;
  localparam int WUTC_ROLL_BIT      = 3;
  localparam int WUTC_SYNC_BIT      = 8;
  localparam int WUTC_NUM_CMP       = 3;

  localparam logic [31:0] WUTC_COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] WUTC_COUNT_FULL = 32'hFFFF_FFFF;

  // Counting tick derived from the system clock
  localparam int WUTC_SYS_CLK_HZ  = 50_000_000;
  localparam int WUTC_LF_CLK_HZ   = 32_768;
  localparam int WUTC_TICK_CYCLES = WUTC_SYS_CLK_HZ / WUTC_LF_CLK_HZ;
endpackage

/* File: hdl/wutc_tick_divider.sv */
`timescale 1ns/1ps
module wutc_tick_divider
  import wutc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Tick output
  output logic      tick
);
  logic [11:0] count_r;
  logic [11:0] count_nxt;
  logic        tick_r;
  logic        tick_nxt;

  localparam logic [11:0] LAST = 12'(WUTC_TICK_CYCLES - 1);

  always_comb
  begin
    tick_nxt  = 1'b0;
    count_nxt = count_r + 12'h001;
    if (count_r == LAST)
    begin
      count_nxt = 12'h000;
      tick_nxt  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= 12'h000;
      tick_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // wutc_tick_divider

/* File: hdl/wutc_compare.sv */
`timescale 1ns/1ps
module wutc_compare
  import wutc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Comparison inputs
  input  wire logic        tick,
  input  wire logic        running,
  input  wire logic        match_enable,
  input  wire logic [31:0] count,
  input  wire logic [31:0] field,
  // One-cycle hit
  output logic             hit
);
  logic hit_r;
  logic hit_nxt;

  // No comparison at all while the enable is clear
  always_comb
  begin
    hit_nxt = 1'b0;
    if (match_enable && running && tick)
    begin
      hit_nxt = (count == field);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hit_r <= 1'b0;
    end
    else
    begin
      hit_r <= hit_nxt;
    end
  end

  assign hit = hit_r;
endmodule // wutc_compare

/* File: hdl/wutc_top.sv */
// Summary of operation
// - Counter held at start value while enable is 0, counts when 1.
// - Outside free-running mode, counter restarts after reaching field C.
// - Each match enable gates its comparison; no flag set while clear.
// - Rollover enable raises an interrupt on free-running wrap.
// - Match enables raise interrupts when counter reaches A, B or C.
// - Each compare field joins a low and a high 16-bit register.
// - Low halves reset to 1FFF, 2FFF, 3FFF; high halves to zero.
// - Sync flag set on enable change, cleared once counter takes it.
// - Periodic up counts 0 to C; periodic down full scale to C.
// - Match flags set on enabled hit, cleared by interrupt clear write.
`timescale 1ns/1ps
module wutc_top
  import wutc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             timer_irq
);
  // Register state
  logic        enable_r,     enable_nxt;
  logic        running_r,    running_nxt;
  logic        sync_r,       sync_nxt;
  logic [1:0]  control_r,    control_nxt;
  logic [15:0] cmp_low_r  [WUTC_NUM_CMP];
  logic [15:0] cmp_low_nxt [WUTC_NUM_CMP];
  logic [15:0] cmp_high_r [WUTC_NUM_CMP];
  logic [15:0] cmp_high_nxt [WUTC_NUM_CMP];
  logic [3:0]  irq_en_r,     irq_en_nxt;
  logic [3:0]  flags_r,      flags_nxt;
  logic [31:0] count_r,      count_nxt;
  logic        roll_r,       roll_nxt;
  logic        ack_r,        ack_nxt;
  logic [31:0] rdata_r,      rdata_nxt;

  // Decoded helpers
  logic        tick;
  logic        req;
  logic        wr;
  logic        free_run;
  logic        count_down;
  logic [31:0] start_value;
  logic [31:0] field     [WUTC_NUM_CMP];
  logic [WUTC_NUM_CMP-1:0] hit;
  logic [15:0] wdata;
  logic [15:0] wmask;

  localparam logic [15:0] LOW_BYTE  = 16'h00FF;
  localparam logic [15:0] HIGH_BYTE = 16'hFF00;

  wutc_tick_divider u_tick
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < WUTC_NUM_CMP; gi++)
    begin : g_cmp
      assign field[gi] = {cmp_high_r[gi], cmp_low_r[gi]};
      wutc_compare u_cmp
      (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .tick         (tick),
        .running      (running_r),
        .match_enable (irq_en_r[gi]),
        .count        (count_r),
        .field        (field[gi]),
        .hit          (hit[gi])
      );
    end
  endgenerate

  assign req         = wb_cyc_i && wb_stb_i;
  // Writes land on the acknowledging edge only
  assign wr          = req && wb_we_i && ack_r;
  assign free_run    = control_r[WUTC_CTRL_FREE_BIT];
  assign count_down  = control_r[WUTC_CTRL_DEC_BIT];
  assign start_value = count_down ? WUTC_COUNT_FULL : WUTC_COUNT_ZERO;
  assign wdata       = wb_dat_i[15:0];
  assign wmask       = (wb_sel_i[0] ? LOW_BYTE : 16'h0000) |
                       (wb_sel_i[1] ? HIGH_BYTE : 16'h0000);

  // Bus handshake and read data
  always_comb
  begin
    ack_nxt   = req && !ack_r;
    rdata_nxt = rdata_r;
    if (req && !ack_r)
    begin
      case (wb_adr_i)
        WUTC_ADDR_VALUE_LOW:  rdata_nxt = {16'h0000, count_r[15:0]};
        WUTC_ADDR_VALUE_HIGH: rdata_nxt = {16'h0000, count_r[31:16]};
        WUTC_ADDR_CONTROL:    rdata_nxt = {30'h0, control_r};
        WUTC_ADDR_ENABLE:     rdata_nxt = {31'h0, enable_r};
        WUTC_ADDR_CMP_A_LOW:  rdata_nxt = {16'h0000, cmp_low_r[0]};
        WUTC_ADDR_CMP_A_HIGH: rdata_nxt = {16'h0000, cmp_high_r[0]};
        WUTC_ADDR_CMP_B_LOW:  rdata_nxt = {16'h0000, cmp_low_r[1]};
        WUTC_ADDR_CMP_B_HIGH: rdata_nxt = {16'h0000, cmp_high_r[1]};
        WUTC_ADDR_CMP_C_LOW:  rdata_nxt = {16'h0000, cmp_low_r[2]};
        WUTC_ADDR_CMP_C_HIGH: rdata_nxt = {16'h0000, cmp_high_r[2]};
        WUTC_ADDR_IRQ_ENABLE: rdata_nxt = {28'h0, irq_en_r};
        WUTC_ADDR_IRQ_STATUS: rdata_nxt = {23'h0, sync_r, 4'h0, flags_r};
        default:              rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Software registers
  always_comb
  begin
    enable_nxt  = enable_r;
    control_nxt = control_r;
    irq_en_nxt  = irq_en_r;
    for (int i = 0; i < WUTC_NUM_CMP; i++)
    begin
      cmp_low_nxt[i]  = cmp_low_r[i];
      cmp_high_nxt[i] = cmp_high_r[i];
    end
    if (wr)
    begin
      case (wb_adr_i)
        WUTC_ADDR_ENABLE:
        begin
          // Unused upper bits are not stored
          if (wb_sel_i[0])
          begin
            enable_nxt = wdata[WUTC_ENABLE_BIT];
          end
        end
        WUTC_ADDR_CONTROL:
        begin
          if (wb_sel_i[0])
          begin
            control_nxt = wdata[1:0];
          end
        end
        WUTC_ADDR_IRQ_ENABLE:
        begin
          if (wb_sel_i[0])
          begin
            irq_en_nxt = wdata[3:0];
          end
        end
        WUTC_ADDR_CMP_A_LOW:
          cmp_low_nxt[0] = (cmp_low_r[0] & ~wmask) | (wdata & wmask);
        WUTC_ADDR_CMP_A_HIGH:
          cmp_high_nxt[0] = (cmp_high_r[0] & ~wmask) | (wdata & wmask);
        WUTC_ADDR_CMP_B_LOW:
          cmp_low_nxt[1] = (cmp_low_r[1] & ~wmask) | (wdata & wmask);
        WUTC_ADDR_CMP_B_HIGH:
          cmp_high_nxt[1] = (cmp_high_r[1] & ~wmask) | (wdata & wmask);
        WUTC_ADDR_CMP_C_LOW:
          cmp_low_nxt[2] = (cmp_low_r[2] & ~wmask) | (wdata & wmask);
        WUTC_ADDR_CMP_C_HIGH:
          cmp_high_nxt[2] = (cmp_high_r[2] & ~wmask) | (wdata & wmask);
        default:
          enable_nxt = enable_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_r      <= WUTC_RST_ENABLE[0];
      control_r     <= WUTC_RST_CONTROL[1:0];
      irq_en_r      <= WUTC_RST_IRQ_ENABLE[3:0];
      cmp_low_r[0]  <= WUTC_RST_CMP_A_LOW;
      cmp_low_r[1]  <= WUTC_RST_CMP_B_LOW;
      cmp_low_r[2]  <= WUTC_RST_CMP_C_LOW;
      for (int i = 0; i < WUTC_NUM_CMP; i++)
      begin
        cmp_high_r[i] <= WUTC_RST_CMP_HIGH;
      end
    end
    else
    begin
      enable_r  <= enable_nxt;
      control_r <= control_nxt;
      irq_en_r  <= irq_en_nxt;
      for (int i = 0; i < WUTC_NUM_CMP; i++)
      begin
        cmp_low_r[i]  <= cmp_low_nxt[i];
        cmp_high_r[i] <= cmp_high_nxt[i];
      end
    end
  end

  // Counter, enable hand-over and flags
  always_comb
  begin
    running_nxt = running_r;
    sync_nxt    = sync_r;
    count_nxt   = count_r;
    roll_nxt    = 1'b0;
    flags_nxt   = flags_r;
    // The counting side adopts the enable only on a tick
    if (tick)
    begin
      running_nxt = enable_r;
      sync_nxt    = 1'b0;
    end
    // A fresh change wins over the tick that clears the flag
    if (enable_nxt != enable_r)
    begin
      sync_nxt = 1'b1;
    end
    if (!running_r)
    begin
      count_nxt = start_value;
    end
    else if (tick)
    begin
      if (!free_run && count_r == field[2])
      begin
        count_nxt = start_value;
      end
      else if (count_down)
      begin
        count_nxt = count_r - 32'h0000_0001;
        roll_nxt  = free_run && irq_en_r[WUTC_ROLL_BIT] &&
                    count_r == WUTC_COUNT_ZERO;
      end
      else
      begin
        count_nxt = count_r + 32'h0000_0001;
        roll_nxt  = free_run && irq_en_r[WUTC_ROLL_BIT] &&
                    count_r == WUTC_COUNT_FULL;
      end
    end
    // Clear first, so an event in the same cycle still sets
    if (wr && wb_adr_i == WUTC_ADDR_IRQ_CLEAR && wb_sel_i[0])
    begin
      flags_nxt = flags_r & ~wdata[3:0];
    end
    flags_nxt = flags_nxt | {roll_r, hit};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      running_r <= 1'b0;
      sync_r    <= 1'b0;
      count_r   <= WUTC_COUNT_ZERO;
      roll_r    <= 1'b0;
      flags_r   <= 4'h0;
    end
    else
    begin
      running_r <= running_nxt;
      sync_r    <= sync_nxt;
      count_r   <= count_nxt;
      roll_r    <= roll_nxt;
      flags_r   <= flags_nxt;
    end
  end

  assign timer_irq = |flags_r;
endmodule // wutc_top

/* File: dv/wutc_top_assertions.sv */
`timescale 1ns/1ps
module wutc_checker
  import wutc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Interrupt
  input wire logic        timer_irq
);
  logic [3:0] ien_r;
  logic [3:0] ien_nxt;
  logic       clr_wr;
  assign clr_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
                  && wb_adr_i == WUTC_ADDR_IRQ_CLEAR;
  // Shadow of the enables, so a rising interrupt can be traced to a cause
  always_comb
  begin
    ien_nxt = ien_r;
    if (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == WUTC_ADDR_IRQ_ENABLE)
      ien_nxt = wb_dat_i[3:0];
  end
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      ien_r <= 4'h0;
    else
      ien_r <= ien_nxt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between accesses");
  dat_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i[31:8] != 24'h400025 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  irq_clear_a: assert property (clr_wr && wb_dat_i[3:0] == 4'hF
    |-> ##[1:3] !timer_irq)
    else $error("interrupt stays after clear");
  irq_fall_a: assert property ($fell(timer_irq) |-> $past(clr_wr)
    || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("interrupt dropped without clear");
  irq_cause_a: assert property ($rose(timer_irq) |-> ien_r != 4'h0)
    else $error("interrupt with all enables clear");
endmodule // wutc_checker
bind wutc_top wutc_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_irq(timer_irq));

/* File: dv/tb_wakeup_timer_compare.sv */
`timescale 1ns/1ps
module tb_wakeup_timer_compare
  import wutc_pkg::*;
;
  logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r, m;
  logic [3:0]  wb_sel_i;
  logic        wb_ack_o, timer_irq;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_count, tests_run, i;
  wutc_top dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_irq(timer_irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until ack is sampled, then one idle cycle
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      err_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] a, x, k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    repeat (4) @(posedge sys_clk);
    while (timer_irq !== 1'b1 && n < 8000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 8000)
      err_count++;
  endtask
  always @(posedge sys_clk)
    if (!rst && wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
    begin
      m = msk_q.pop_front();
      check("read", wb_dat_o & m, exp_q.pop_front() & m);
    end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    void'($urandom(51));
    rd(WUTC_ADDR_ENABLE, 32'h0, 32'hFFFF_FFFF);
    rd(WUTC_ADDR_IRQ_ENABLE, 32'h0, 32'hFFFF_FFFF);
    rd(WUTC_ADDR_CMP_A_LOW, 32'h1FFF, 32'hFFFF_FFFF);
    rd(WUTC_ADDR_CMP_B_LOW, 32'h2FFF, 32'hFFFF_FFFF);
    rd(WUTC_ADDR_CMP_C_LOW, 32'h3FFF, 32'hFFFF_FFFF);
    for (i = 0; i < 3; i++)
      rd(WUTC_ADDR_CMP_A_HIGH + 8 * i, 32'h0, 32'hFFFF_FFFF);
    rd(32'h4000_2600, 32'h0, 32'hFFFF_FFFF);
    // Enables are still clear, so fields may change freely
    for (i = 0; i < 6; i++)
    begin
      r = $urandom;
      xfer(WUTC_ADDR_CMP_A_LOW + 4 * i, 1'b1, r);
      rd(WUTC_ADDR_CMP_A_LOW + 4 * i, {16'h0, r[15:0]}, 32'hFFFF_FFFF);
    end
    // Periodic up: A=1, B=0 left unarmed, C=2
    xfer(WUTC_ADDR_CONTROL, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CMP_A_LOW, 1'b1, 32'h1);
    xfer(WUTC_ADDR_CMP_A_HIGH, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CMP_B_LOW, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CMP_B_HIGH, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CMP_C_LOW, 1'b1, 32'h2);
    xfer(WUTC_ADDR_CMP_C_HIGH, 1'b1, 32'h0);
    xfer(WUTC_ADDR_IRQ_ENABLE, 1'b1, 32'h5);
    xfer(WUTC_ADDR_ENABLE, 1'b1, 32'h1);
    rd(WUTC_ADDR_IRQ_STATUS, 32'h100, 32'h100);
    for (i = 0; i < 3; i++)
    begin
      wait_irq();
      check("irq", {31'h0, timer_irq}, 32'h1);
      rd(WUTC_ADDR_IRQ_STATUS, i == 1 ? 32'h4 : 32'h1, 32'h10F);
      xfer(WUTC_ADDR_IRQ_CLEAR, 1'b1, 32'hF);
      rd(WUTC_ADDR_IRQ_STATUS, 32'h0, 32'h10F);
    end
    xfer(WUTC_ADDR_ENABLE, 1'b1, 32'h0);
    repeat (3200) @(posedge sys_clk);
    // A last hit may land before the disable reaches the counter
    xfer(WUTC_ADDR_IRQ_CLEAR, 1'b1, 32'hF);
    rd(WUTC_ADDR_IRQ_STATUS, 32'h0, 32'h10F);
    rd(WUTC_ADDR_VALUE_LOW, 32'h0, 32'hFFFF);
    // Periodic down to C, rollover armed but not free running
    xfer(WUTC_ADDR_IRQ_ENABLE, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CONTROL, 1'b1, 32'h2);
    xfer(WUTC_ADDR_CMP_C_LOW, 1'b1, 32'hFFFD);
    xfer(WUTC_ADDR_CMP_C_HIGH, 1'b1, 32'hFFFF);
    xfer(WUTC_ADDR_IRQ_ENABLE, 1'b1, 32'hC);
    xfer(WUTC_ADDR_ENABLE, 1'b1, 32'h1);
    wait_irq();
    rd(WUTC_ADDR_IRQ_STATUS, 32'h4, 32'h10F);
    xfer(WUTC_ADDR_IRQ_CLEAR, 1'b1, 32'hF);
    xfer(WUTC_ADDR_ENABLE, 1'b1, 32'h0);
    repeat (3200) @(posedge sys_clk);
    rd(WUTC_ADDR_VALUE_HIGH, 32'hFFFF, 32'hFFFF);
    // Free running up: no reload at C, so A beyond C is still reached
    xfer(WUTC_ADDR_IRQ_ENABLE, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CONTROL, 1'b1, 32'h1);
    xfer(WUTC_ADDR_CMP_A_LOW, 1'b1, 32'h2);
    xfer(WUTC_ADDR_CMP_A_HIGH, 1'b1, 32'h0);
    xfer(WUTC_ADDR_CMP_C_LOW, 1'b1, 32'h1);
    xfer(WUTC_ADDR_CMP_C_HIGH, 1'b1, 32'h0);
    xfer(WUTC_ADDR_IRQ_ENABLE, 1'b1, 32'hD);
    xfer(WUTC_ADDR_ENABLE, 1'b1, 32'h1);
    for (i = 0; i < 2; i++)
    begin
      wait_irq();
      rd(WUTC_ADDR_IRQ_STATUS, i == 0 ? 32'h4 : 32'h1, 32'h10F);
      xfer(WUTC_ADDR_IRQ_CLEAR, 1'b1, 32'hF);
    end
    summarize();
  end
endmodule // tb_wakeup_timer_compare
